// [hw/timer16_counter_input_capture.sv]
// 16-bit timer counter with input capture, byte-wide register port
`timescale 1ns/1ps
// Behaviour
// - 16-bit counter steps up or down one per timer tick by direction.
// - clear forces every counter bit to zero.
// - bottom flags zero; top flags the highest value of the sequence.
// - counter low-byte read loads shared latch with the upper byte.
// - counter low-byte write loads upper from latch, lower from data.
// - clock source select zero stops ticks; counter holds.
// - processor reads and writes counter with or without ticks.
// - processor write to counter beats clear and count.
// - four waveform mode bits across two controls pick the sequence.
// - overflow flag set per mode; usable as interrupt request.
// - matching edge on capture source copies counter to capture register.
// - capture flag sets in the same cycle as the copy.
// - capture flag requests irq when enabled; cleared by service or one.
// - capture low read loads latch; high location reads the latch.
// - capture register writable only in capture-top modes, high first.
// - capture pin is default source; comparator when select bit set.
// - edge detector off in capture-top modes; the filter keeps sampling.
// - filter output changes after four agreeing samples.
// - filter enable bit in control b; filter on system clock.
// - each capture overwrites the capture register.
// - software-driven port level on capture pin acts as an event.
// - top is 0x00FF, 0x01FF, 0x03FF, compare a or capture register.
// - 0xFFFF is the counting maximum.
module timer16_counter_input_capture (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic tick_in,
	input wire logic capture_input_pin,
	input wire logic comparator_output,
	input wire logic ovf_irq_ack,
	input wire logic capt_irq_ack,
	output logic ovf_irq,
	output logic capt_irq,
	output logic top_hit,
	output logic bottom_hit
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [15:0] count_value_ff;
	logic [15:0] nxt_count_value;
	logic [15:0] capture_register_ff;
	logic [15:0] compare_register_a_ff;
	logic [7:0] temp_ff;
	logic [7:0] timer_control_a_ff;
	logic [7:0] timer_control_b_ff;
	logic [7:0] comparator_ctrl_status_ff;
	logic [7:0] irq_en_ff;
	logic overflow_flag_ff;
	logic capture_flag_ff;
	logic dir_down_ff;
	logic [7:0] bus_rdata_ff;
	logic ovf_irq_ff;
	logic capt_irq_ff;
	logic top_ff;
	logic bottom_ff;
	logic [2:0] pin_sync_ff;

	// ------------------------------------------------------------
	// decoded control
	// ------------------------------------------------------------
	logic [3:0] waveform_mode_bits;
	logic [2:0] clock_source_select;
	logic timer_tick;
	logic [15:0] top_value;
	timer16_pkg::seq_kind_t seq_kind;
	logic capt_top_mode;
	logic capt_src;
	logic capt_level_ff;
	logic edge_hit;
	logic wr_count_lo;
	logic wr_capt_lo;
	logic rd_count_lo;
	logic rd_capt_lo;
	logic at_top;
	logic at_bottom;
	logic ovf_event;

	assign waveform_mode_bits = {
		timer_control_b_ff[timer16_pkg::CTRL_B_WGM_HI_LSB +: 2],
		timer_control_a_ff[timer16_pkg::CTRL_A_WGM_LSB +: 2]};
	assign clock_source_select = timer_control_b_ff[timer16_pkg::CTRL_B_CS_LSB +: 3];
	assign timer_tick = (clock_source_select != 3'h0) & tick_in;

	// mode decode: top source and sequence kind
	function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] cmp_a,
		input logic [15:0] capt);
		case (m)
			4'h1, 4'h5: mode_top = timer16_pkg::TOP_8BIT;
			4'h2, 4'h6: mode_top = timer16_pkg::TOP_9BIT;
			4'h3, 4'h7: mode_top = timer16_pkg::TOP_10BIT;
			4'h4, 4'h9, 4'hB, 4'hF: mode_top = cmp_a;
			4'h8, 4'hA, 4'hC, 4'hE: mode_top = capt;
			default: mode_top = timer16_pkg::MAX_VALUE;
		endcase
	endfunction

	function automatic logic uses_capture_top(input logic [3:0] m);
		uses_capture_top = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
	endfunction

	always_comb begin
		case (waveform_mode_bits)
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: seq_kind = timer16_pkg::SEQ_UP_DOWN;
			4'h4, 4'hC, 4'h5, 4'h6, 4'h7, 4'hE, 4'hF: seq_kind = timer16_pkg::SEQ_UP_CLEAR;
			default: seq_kind = timer16_pkg::SEQ_UP_WRAP;
		endcase
	end

	assign top_value = mode_top(waveform_mode_bits, compare_register_a_ff, capture_register_ff);
	assign capt_top_mode = uses_capture_top(waveform_mode_bits);
	assign at_top = (count_value_ff == top_value);
	assign at_bottom = (count_value_ff == timer16_pkg::BOTTOM_VALUE);

	// ------------------------------------------------------------
	// bus strobes
	// ------------------------------------------------------------
	assign wr_count_lo = bus_wr && (bus_addr == timer16_pkg::ADDR_COUNT_LO);
	assign wr_capt_lo = bus_wr && (bus_addr == timer16_pkg::ADDR_CAPT_LO) && capt_top_mode;
	assign rd_count_lo = bus_rd && (bus_addr == timer16_pkg::ADDR_COUNT_LO);
	assign rd_capt_lo = bus_rd && (bus_addr == timer16_pkg::ADDR_CAPT_LO);

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	always_comb begin
		nxt_count_value = count_value_ff;
		if (wr_count_lo) begin
			nxt_count_value = {temp_ff, bus_wdata};
		end else if (timer_tick) begin
			if (seq_kind == timer16_pkg::SEQ_UP_DOWN) begin
				if (dir_down_ff) begin
					nxt_count_value = count_value_ff - 16'h0001;
				end else begin
					nxt_count_value = count_value_ff + 16'h0001;
				end
			end else if (seq_kind == timer16_pkg::SEQ_UP_CLEAR && at_top) begin
				nxt_count_value = 16'h0000;
			end else begin
				nxt_count_value = count_value_ff + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count_value_ff <= timer16_pkg::COUNT_RESET;
		end else begin
			count_value_ff <= nxt_count_value;
		end
	end

	// direction for dual-slope sequences
	always_ff @(posedge clk) begin
		if (reset) begin
			dir_down_ff <= 1'b0;
		end else if (seq_kind != timer16_pkg::SEQ_UP_DOWN) begin
			dir_down_ff <= 1'b0;
		end else if (timer_tick && !wr_count_lo) begin
			if (!dir_down_ff && nxt_count_value == top_value) begin
				dir_down_ff <= 1'b1;
			end else if (dir_down_ff && nxt_count_value == timer16_pkg::BOTTOM_VALUE) begin
				dir_down_ff <= 1'b0;
			end
		end
	end

	// overflow point depends on the sequence
	always_comb begin
		ovf_event = 1'b0;
		if (timer_tick && !wr_count_lo) begin
			case (seq_kind)
				timer16_pkg::SEQ_UP_DOWN: ovf_event = dir_down_ff && (count_value_ff == 16'h0001);
				timer16_pkg::SEQ_UP_CLEAR: ovf_event = at_top;
				default: ovf_event = (count_value_ff == timer16_pkg::MAX_VALUE);
			endcase
		end
	end

	// ------------------------------------------------------------
	// capture path
	// ------------------------------------------------------------
	// port-driven levels reach the pin input too, so they trigger alike
	assign capt_src = comparator_ctrl_status_ff[timer16_pkg::COMP_CAPT_SEL_BIT]
		? comparator_output : capture_input_pin;

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_sync_ff <= 3'h0;
		end else begin
			pin_sync_ff <= {pin_sync_ff[1:0], capt_src};
		end
	end

	// change counts once second and third stages agree
	always_ff @(posedge clk) begin
		if (reset) begin
			capt_level_ff <= 1'b0;
		end else if (pin_sync_ff[1] == pin_sync_ff[2]) begin
			capt_level_ff <= pin_sync_ff[2];
		end
	end

	capture_filter #(
		.SAMPLES(timer16_pkg::FILTER_SAMPLES)
	) u_filter (
		.clk(clk),
		.reset(reset),
		.sample_in(capt_level_ff),
		.filter_on(timer_control_b_ff[timer16_pkg::CTRL_B_FILT_BIT]),
		.detect_on(!capt_top_mode),
		.rising_sel(timer_control_b_ff[timer16_pkg::CTRL_B_EDGE_BIT]),
		.edge_hit(edge_hit)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			capture_register_ff <= timer16_pkg::COUNT_RESET;
		end else if (wr_capt_lo) begin
			capture_register_ff <= {temp_ff, bus_wdata};
		end else if (edge_hit) begin
			capture_register_ff <= count_value_ff;
		end
	end

	// set wins over clear
	always_ff @(posedge clk) begin
		if (reset) begin
			capture_flag_ff <= 1'b0;
		end else if (edge_hit) begin
			capture_flag_ff <= 1'b1;
		end else if (capt_irq_ack || (bus_wr && bus_addr == timer16_pkg::ADDR_FLAGS
			&& bus_wdata[timer16_pkg::FLAG_CAPT_BIT])) begin
			capture_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			overflow_flag_ff <= 1'b0;
		end else if (ovf_event) begin
			overflow_flag_ff <= 1'b1;
		end else if (ovf_irq_ack || (bus_wr && bus_addr == timer16_pkg::ADDR_FLAGS
			&& bus_wdata[timer16_pkg::FLAG_OVF_BIT])) begin
			overflow_flag_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// register writes and shared latch
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			temp_ff <= 8'h00;
		end else if (rd_count_lo) begin
			temp_ff <= count_value_ff[15:8];
		end else if (rd_capt_lo) begin
			temp_ff <= capture_register_ff[15:8];
		end else if (bus_wr && (bus_addr == timer16_pkg::ADDR_COUNT_HI
			|| bus_addr == timer16_pkg::ADDR_CAPT_HI
			|| bus_addr == timer16_pkg::ADDR_CMP_A_HI)) begin
			temp_ff <= bus_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			timer_control_a_ff <= timer16_pkg::CTRL_RESET;
			timer_control_b_ff <= timer16_pkg::CTRL_RESET;
			comparator_ctrl_status_ff <= timer16_pkg::CTRL_RESET;
			irq_en_ff <= timer16_pkg::CTRL_RESET;
			compare_register_a_ff <= timer16_pkg::MAX_VALUE;
		end else if (bus_wr) begin
			if (bus_addr == timer16_pkg::ADDR_CTRL_A) begin
				timer_control_a_ff <= bus_wdata;
			end else if (bus_addr == timer16_pkg::ADDR_CTRL_B) begin
				timer_control_b_ff <= bus_wdata;
			end else if (bus_addr == timer16_pkg::ADDR_COMP_CTRL) begin
				comparator_ctrl_status_ff <= bus_wdata;
			end else if (bus_addr == timer16_pkg::ADDR_IRQ_EN) begin
				irq_en_ff <= bus_wdata;
			end else if (bus_addr == timer16_pkg::ADDR_CMP_A_LO) begin
				compare_register_a_ff <= {temp_ff, bus_wdata};
			end
		end
	end

	// ------------------------------------------------------------
	// read data and outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			bus_rdata_ff <= 8'h00;
		end else if (!bus_rd) begin
			bus_rdata_ff <= 8'h00;
		end else if (bus_addr == timer16_pkg::ADDR_COUNT_LO) begin
			bus_rdata_ff <= count_value_ff[7:0];
		end else if (bus_addr == timer16_pkg::ADDR_COUNT_HI
			|| bus_addr == timer16_pkg::ADDR_CAPT_HI) begin
			bus_rdata_ff <= temp_ff;
		end else if (bus_addr == timer16_pkg::ADDR_CAPT_LO) begin
			bus_rdata_ff <= capture_register_ff[7:0];
		end else if (bus_addr == timer16_pkg::ADDR_CTRL_A) begin
			bus_rdata_ff <= timer_control_a_ff;
		end else if (bus_addr == timer16_pkg::ADDR_CTRL_B) begin
			bus_rdata_ff <= timer_control_b_ff;
		end else if (bus_addr == timer16_pkg::ADDR_FLAGS) begin
			bus_rdata_ff <= 8'h00 | ({7'h00, overflow_flag_ff} << timer16_pkg::FLAG_OVF_BIT)
				| ({7'h00, capture_flag_ff} << timer16_pkg::FLAG_CAPT_BIT);
		end else if (bus_addr == timer16_pkg::ADDR_IRQ_EN) begin
			bus_rdata_ff <= irq_en_ff;
		end else if (bus_addr == timer16_pkg::ADDR_CMP_A_LO) begin
			bus_rdata_ff <= compare_register_a_ff[7:0];
		end else if (bus_addr == timer16_pkg::ADDR_CMP_A_HI) begin
			bus_rdata_ff <= compare_register_a_ff[15:8];
		end else if (bus_addr == timer16_pkg::ADDR_COMP_CTRL) begin
			bus_rdata_ff <= comparator_ctrl_status_ff;
		end else begin
			bus_rdata_ff <= 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ovf_irq_ff <= 1'b0;
			capt_irq_ff <= 1'b0;
			top_ff <= 1'b0;
			bottom_ff <= 1'b0;
		end else begin
			ovf_irq_ff <= overflow_flag_ff & irq_en_ff[timer16_pkg::FLAG_OVF_BIT];
			capt_irq_ff <= capture_flag_ff & irq_en_ff[timer16_pkg::FLAG_CAPT_BIT];
			top_ff <= at_top;
			bottom_ff <= at_bottom;
		end
	end

	assign bus_rdata = bus_rdata_ff;
	assign ovf_irq = ovf_irq_ff;
	assign capt_irq = capt_irq_ff;
	assign top_hit = top_ff;
	assign bottom_hit = bottom_ff;

endmodule

// [hw/timer16_pkg.sv]
// constants for the 16-bit timer with input capture
package timer16_pkg;

	// byte locations on the processor bus
	localparam logic [3:0] ADDR_COUNT_LO = 4'h0;
	localparam logic [3:0] ADDR_COUNT_HI = 4'h1;
	localparam logic [3:0] ADDR_CAPT_LO = 4'h2;
	localparam logic [3:0] ADDR_CAPT_HI = 4'h3;
	localparam logic [3:0] ADDR_CTRL_A = 4'h4;
	localparam logic [3:0] ADDR_CTRL_B = 4'h5;
	localparam logic [3:0] ADDR_FLAGS = 4'h6;
	localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
	localparam logic [3:0] ADDR_CMP_A_LO = 4'h8;
	localparam logic [3:0] ADDR_CMP_A_HI = 4'h9;
	localparam logic [3:0] ADDR_COMP_CTRL = 4'hA;

	// control a: waveform mode bits 1:0
	localparam int CTRL_A_WGM_LSB = 0;
	// control b fields
	localparam int CTRL_B_CS_LSB = 0;
	localparam int CTRL_B_WGM_HI_LSB = 3;
	localparam int CTRL_B_EDGE_BIT = 6;
	localparam int CTRL_B_FILT_BIT = 7;
	// flag register bits
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CAPT_BIT = 5;
	// comparator control: capture select bit
	localparam int COMP_CAPT_SEL_BIT = 2;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	localparam logic [15:0] BOTTOM_VALUE = 16'h0000;
	localparam logic [15:0] MAX_VALUE = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;

	localparam int FILTER_SAMPLES = 4;

	typedef enum logic [1:0] {
		SEQ_UP_WRAP,
		SEQ_UP_CLEAR,
		SEQ_UP_DOWN
	} seq_kind_t;

endpackage

// [hw/capture_filter.sv]
// noise filter and edge detector for the capture source
`timescale 1ns/1ps
module capture_filter #(
	parameter int SAMPLES = timer16_pkg::FILTER_SAMPLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic sample_in,
	input wire logic filter_on,
	input wire logic detect_on,
	input wire logic rising_sel,
	output logic edge_hit
);

	logic [SAMPLES-1:0] hist_ff;
	logic filt_ff;
	logic prev_ff;
	logic src_now;

	always_ff @(posedge clk) begin
		if (reset) begin
			hist_ff <= '0;
		end else begin
			hist_ff <= {hist_ff[SAMPLES-2:0], sample_in};
		end
	end

	// output changes only when all samples agree
	always_ff @(posedge clk) begin
		if (reset) begin
			filt_ff <= 1'b0;
		end else if (&hist_ff) begin
			filt_ff <= 1'b1;
		end else if (~|hist_ff) begin
			filt_ff <= 1'b0;
		end
	end

	assign src_now = filter_on ? filt_ff : sample_in;

	always_ff @(posedge clk) begin
		if (reset) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= src_now;
		end
	end

	// edge detector gated off in capture-top modes
	always_comb begin
		if (!detect_on) begin
			edge_hit = 1'b0;
		end else if (rising_sel) begin
			edge_hit = src_now & ~prev_ff;
		end else begin
			edge_hit = ~src_now & prev_ff;
		end
	end

endmodule

// [verification/timer16_properties.sv]
// assertions on the ports of the 16-bit timer core
`timescale 1ns/1ps
module timer16_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic tick_in,
	input wire logic capture_input_pin,
	input wire logic comparator_output,
	input wire logic ovf_irq_ack,
	input wire logic capt_irq_ack,
	input wire logic ovf_irq,
	input wire logic capt_irq,
	input wire logic top_hit,
	input wire logic bottom_hit
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic pin_ff;
	logic comp_ff;
	logic [4:0] quiet_ff;
	logic [2:0] age_ff;
	always_ff @(posedge clk) begin
		pin_ff <= capture_input_pin;
		comp_ff <= comparator_output;
	end
	// cycles since a source change or any register write
	always_ff @(posedge clk) begin
		if (reset || bus_wr || capture_input_pin != pin_ff || comparator_output != comp_ff)
			quiet_ff <= 5'h00;
		else if (quiet_ff != 5'h1F)
			quiet_ff <= quiet_ff + 5'h01;
	end
	always_ff @(posedge clk) begin
		if (reset)
			age_ff <= 3'h0;
		else if (age_ff != 3'h7)
			age_ff <= age_ff + 3'h1;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
		else $error("read data not zero without a read");
	a_unmapped_zero: assert property (
		bus_rd && bus_addr > timer16_pkg::ADDR_COMP_CTRL |=> bus_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_write_zero_bottom: assert property (
		bus_wr && bus_addr == timer16_pkg::ADDR_COUNT_HI && bus_wdata == 8'h00 ##[1:2]
		bus_wr && bus_addr == timer16_pkg::ADDR_COUNT_LO && bus_wdata == 8'h00
		|-> ##2 bottom_hit)
		else $error("zero write did not reach bottom");
	a_ovf_ack_clears: assert property (
		ovf_irq_ack && !tick_in ##1 !tick_in |=> !ovf_irq)
		else $error("overflow request stayed after service");
	a_ovf_has_cause: assert property (
		$rose(ovf_irq) |-> $past(tick_in, 2) || $past(bus_wr, 2))
		else $error("overflow request without tick");
	a_capt_ack_clears: assert property (
		capt_irq_ack && quiet_ff > 5'h0C |-> ##2 !capt_irq)
		else $error("capture request stayed after service");
	a_capt_has_cause: assert property ($rose(capt_irq) |-> quiet_ff < 5'h10)
		else $error("capture request without source edge");
	a_hold_no_tick: assert property (
		!tick_in && !bus_wr && age_ff == 3'h7 |=> ##1 $stable(bottom_hit) && $stable(top_hit))
		else $error("counter moved without tick or write");
	c_capture: cover property ($rose(capt_irq));
	c_overflow: cover property ($rose(ovf_irq));
	c_top: cover property ($rose(top_hit));
endmodule

bind timer16_counter_input_capture timer16_properties chk_u (
	.clk, .reset, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .tick_in,
	.capture_input_pin, .comparator_output, .ovf_irq_ack, .capt_irq_ack,
	.ovf_irq, .capt_irq, .top_hit, .bottom_hit
);

// [verification/capture_source_model.sv]
// event source: capture pin driver and comparator output
`timescale 1ns/1ps
module capture_source_model (
	input wire logic clk,
	input wire logic pin_level,
	input wire logic comp_level,
	input wire logic pin_glitch,
	output logic capture_input_pin,
	output logic comparator_output
);
	// levels move off the clock edge, as an unsynchronised source would
	always @(posedge clk) begin
		#3 capture_input_pin = pin_level ^ pin_glitch;
		comparator_output = comp_level;
	end
endmodule

// [verification/timer16_counter_input_capture_bench.sv]
// self-checking bench for the 16-bit timer core
`timescale 1ns/1ps
module timer16_counter_input_capture_bench;
	typedef struct packed {
		logic wr;
		logic [3:0] addr;
		logic [7:0] data;
	} row_t;
	localparam logic [3:0] CNT = timer16_pkg::ADDR_COUNT_LO;
	localparam logic [3:0] CAP = timer16_pkg::ADDR_CAPT_LO;
	localparam logic [3:0] CMP = timer16_pkg::ADDR_CMP_A_LO;
	localparam logic [3:0] CA = timer16_pkg::ADDR_CTRL_A;
	localparam logic [3:0] CB = timer16_pkg::ADDR_CTRL_B;
	localparam logic [3:0] FL = timer16_pkg::ADDR_FLAGS;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] bus_addr = 4'h0;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic tick_in = 1'b0;
	logic wr_tick = 1'b0;
	logic ovf_irq_ack = 1'b0;
	logic capt_irq_ack = 1'b0;
	logic pin_level = 1'b0;
	logic comp_level = 1'b0;
	logic pin_glitch = 1'b0;
	logic [7:0] bus_rdata;
	logic capture_input_pin;
	logic comparator_output;
	logic ovf_irq;
	logic capt_irq;
	logic top_hit;
	logic bottom_hit;
	int fails = 0;
	int n_tests = 0;
	// write rows carry data, read rows the expected data
	row_t rows [18] = '{
		'{1'b1, 4'h1, 8'h12}, '{1'b1, 4'h0, 8'h34}, '{1'b0, 4'h0, 8'h34},
		'{1'b0, 4'h1, 8'h12}, '{1'b1, 4'h3, 8'hAB}, '{1'b1, 4'h2, 8'hCD},
		'{1'b0, 4'h2, 8'h00}, '{1'b0, 4'h3, 8'h00}, '{1'b0, 4'h8, 8'hFF},
		'{1'b0, 4'h9, 8'hFF}, '{1'b0, 4'hF, 8'h00}, '{1'b1, 4'h5, 8'h18},
		'{1'b1, 4'h3, 8'hAB}, '{1'b1, 4'h2, 8'hCD}, '{1'b0, 4'h2, 8'hCD},
		'{1'b0, 4'h3, 8'hAB}, '{1'b0, 4'h5, 8'h18}, '{1'b1, 4'h5, 8'h00}};

	always #12.5 clk = ~clk;

	timer16_counter_input_capture dut_u (
		.clk, .reset, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .tick_in,
		.capture_input_pin, .comparator_output, .ovf_irq_ack, .capt_irq_ack,
		.ovf_irq, .capt_irq, .top_hit, .bottom_hit
	);
	capture_source_model src_u (
		.clk, .pin_level, .comp_level, .pin_glitch, .capture_input_pin, .comparator_output
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		tick_in <= wr_tick;
		@(posedge clk);
		bus_wr <= 1'b0;
		tick_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask
	task automatic set16(input logic [3:0] a, input logic [15:0] v);
		wr(a + 4'h1, v[15:8]);
		wr(a, v[7:0]);
	endtask
	task automatic chk16(input string name, input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] v;
		rd(a, v[7:0]);
		rd(a + 4'h1, v[15:8]);
		check(name, v, exp);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick_in <= 1'b1;
			@(posedge clk);
			tick_in <= 1'b0;
		end
	endtask
	task automatic wait_capt(input logic exp);
		for (int i = 0; i < 30 && capt_irq !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		check("capt_irq", {15'h0000, capt_irq}, {15'h0000, exp});
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		logic [7:0] d;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		chk16("count reset", CNT, 16'h0000);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].addr, rows[i].data);
			end else begin
				rd(rows[i].addr, d);
				check("table read", {8'h00, d}, {8'h00, rows[i].data});
			end
		end
		wr(timer16_pkg::ADDR_IRQ_EN, 8'h21);
		set16(CNT, 16'hFFFE);
		wr(CB, 8'h01);
		ticks(1);
		repeat (2) @(posedge clk);
		#1 check("top", {15'h0000, top_hit}, 16'h0001);
		ticks(1);
		repeat (2) @(posedge clk);
		#1 check("bottom", {15'h0000, bottom_hit}, 16'h0001);
		check("ovf", {15'h0000, ovf_irq}, 16'h0001);
		@(posedge clk);
		ovf_irq_ack <= 1'b1;
		@(posedge clk);
		ovf_irq_ack <= 1'b0;
		repeat (2) @(posedge clk);
		#1 check("ovf served", {15'h0000, ovf_irq}, 16'h0000);
		wr(CNT + 4'h1, 8'h00);
		wr_tick = 1'b1;
		wr(CNT, 8'h00);
		wr_tick = 1'b0;
		chk16("write wins", CNT, 16'h0000);
		wr(CB, 8'h00);
		ticks(4);
		chk16("stopped", CNT, 16'h0000);
		wr(CA, 8'h01);
		set16(CNT, 16'h00FE);
		wr(CB, 8'h01);
		ticks(3);
		chk16("down slope", CNT, 16'h00FD);
		set16(CMP, 16'h0010);
		wr(CA, 8'h00);
		set16(CNT, 16'h000F);
		wr(CB, 8'h09);
		ticks(2);
		chk16("clear at top", CNT, 16'h0000);
		wr(CB, 8'h40);
		set16(CNT, 16'h0777);
		wr(FL, 8'h21);
		@(posedge clk);
		pin_level <= 1'b1;
		#1 check("ovf cleared", {15'h0000, ovf_irq}, 16'h0000);
		wait_capt(1'b1);
		chk16("capture", CAP, 16'h0777);
		repeat (4) @(posedge clk);
		capt_irq_ack <= 1'b1;
		@(posedge clk);
		capt_irq_ack <= 1'b0;
		set16(CNT, 16'h0888);
		@(posedge clk);
		pin_level <= 1'b0;
		wait_capt(1'b0);
		wr(CB, 8'hC0);
		@(posedge clk);
		pin_glitch <= 1'b1;
		repeat (2) @(posedge clk);
		pin_glitch <= 1'b0;
		wait_capt(1'b0);
		set16(CNT, 16'h0999);
		@(posedge clk);
		pin_level <= 1'b1;
		wait_capt(1'b1);
		chk16("overwrite", CAP, 16'h0999);
		wr(timer16_pkg::ADDR_COMP_CTRL, 8'h04);
		wr(FL, 8'h20);
		set16(CNT, 16'h0AAA);
		@(posedge clk);
		comp_level <= 1'b1;
		wait_capt(1'b1);
		chk16("comparator", CAP, 16'h0AAA);
		wr(CB, 8'h58);
		wr(FL, 8'h20);
		@(posedge clk);
		comp_level <= 1'b0;
		repeat (12) @(posedge clk);
		comp_level <= 1'b1;
		wait_capt(1'b0);
		wr(CB, 8'h00);
		set16(CNT, 16'h0BBB);
		@(posedge clk);
		comp_level <= 1'b0;
		wait_capt(1'b1);
		chk16("falling", CAP, 16'h0BBB);
		results();
	end
endmodule
